// ---- core/cmas_pkg.sv ----
package cmas_pkg;
    // ------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_COMMAND = 8'h00;
    localparam logic [7:0] ADDR_CELL_COUNT = 8'h01;
    localparam logic [7:0] ADDR_CHANNEL_SEL = 8'h02;
    localparam logic [7:0] ADDR_OVERSAMPLE = 8'h03;
    localparam logic [7:0] ADDR_CELL_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_AUX_PERIOD = 8'h05;
    localparam logic [7:0] ADDR_INTERNAL_PERIOD = 8'h06;
    localparam logic [7:0] ADDR_TEST_CONFIG = 8'h07;
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h20;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h3D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_START_BIT = 0;
    localparam int OVS_CODE_LSB = 0;
    localparam int OVS_CYCLED_BIT = 3;
    localparam int OVS_HPER_LSB = 8;
    localparam int OVS_GPER_LSB = 16;
    localparam int TEST_STACK_EN_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] RST_CELL_COUNT = 5'h10;
    localparam logic [29:0] RST_CHANNEL_SEL = 30'h0000FFFF;
    localparam logic [2:0] RST_OVS_CODE = 3'h0;
    localparam logic [7:0] RST_OVS_PERIOD = 8'h9E;
    localparam logic [15:0] RST_SAMPLE_PERIOD = 16'h009E;

    // ------------------------------------------------------------
    // Channel codes: 0..15 cells 1..16, 16..23 aux, then internal
    // ------------------------------------------------------------
    localparam logic [4:0] CODE_AUX_FIRST = 5'h10;
    localparam logic [4:0] CODE_DIG_TEMP = 5'h18;
    localparam logic [4:0] CODE_ANA_TEMP = 5'h19;
    localparam logic [4:0] CODE_CORE_SUPPLY = 5'h1A;
    localparam logic [4:0] CODE_CMP_REF = 5'h1B;
    localparam logic [4:0] CODE_STACK = 5'h1C;
    localparam logic [4:0] CODE_NEG_RAIL = 5'h1D;
    localparam logic [5:0] POS_INTERNAL = 6'h18;
    localparam logic [5:0] POS_END = 6'h1E;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int HOLD_TIME_NS = 3440;
    localparam int HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CORE_ACQ_NS = 30000;
    localparam int CORE_ACQ_CYC = CORE_ACQ_NS / CLK_PERIOD_NS;
    localparam int DIG_TEMP_ACQ_NS = 50000;
    localparam int DIG_TEMP_ACQ_CYC = DIG_TEMP_ACQ_NS / CLK_PERIOD_NS;
    localparam int PERIOD_UNIT_NS = 80;
    localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_NS / CLK_PERIOD_NS;

    // Sequencer states
    typedef enum logic [1:0] {
        CMAS_IDLE = 2'b00,
        CMAS_SETUP = 2'b01,
        CMAS_ACQ = 2'b10,
        CMAS_CONV = 2'b11
    } cmas_state_t;
endpackage

// ---- core/cmas_sequencer.sv ----
`timescale 1ns/100ps
module cmas_sequencer #(
    parameter int DIG_TEMP_CYC = cmas_pkg::DIG_TEMP_ACQ_CYC
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic broadcast_start_i,
    input wire logic [13:0] adc_data_i,
    output logic [4:0] adc_mux_sel_o,
    output logic adc_hold_o,
    output logic busy_o,
    output logic [15:0] cell_fault_mask_o,
    output logic [15:0] cell_cmp_enable_o
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Position in run order to channel code: cells reversed
    function automatic logic [4:0] pos_code(input logic [5:0] p);
        if (p < 6'h10) begin
            pos_code = 5'(6'h0F - p);
        end else begin
            pos_code = p[4:0];
        end
    endfunction

    // Lowest enabled position in [from, limit), bit 5 = none found
    function automatic logic [5:0] find_pos(input logic [29:0] m,
            input logic [5:0] from, input logic [5:0] limit);
        logic [5:0] res;
        res = 6'h3F;
        for (int p = 29; p >= 0; p--) begin
            if (m[p] && 6'(p) >= from && 6'(p) < limit) begin
                res = 6'(p);
            end
        end
        find_pos = res;
    endfunction

    // Sum of 2^k samples scaled to 16 bits (two gained bits)
    function automatic logic [15:0] scale_avg(input logic [18:0] s,
            input logic [2:0] k);
        logic [20:0] w;
        w = {s, 2'b00} >> k;
        scale_avg = w[15:0];
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [4:0] cell_count_reg; // Cells in use
    logic [29:0] channel_sel; // Enabled channels by code
    logic [2:0] ovs_code; // 0 single, else 2^code samples
    logic cycled_average_select; // Pass-wise averaging
    logic [7:0] high_side_oversample_period; // 80 ns units
    logic [7:0] general_oversample_period; // 80 ns units
    logic [15:0] cell_sample_period_reg; // 80 ns units
    logic [15:0] aux_sample_period_reg; // 80 ns units
    logic [15:0] internal_sample_period_reg; // 80 ns units
    logic stack_voltage_monitor_enable; // Two stack conversions
    logic cmd_start; // Pulse from command write

    // Sequencer state
    cmas_pkg::cmas_state_t state;
    logic [19:0] wait_cnt; // Cycles left in phase
    logic [5:0] pos; // Current run-order position
    logic [4:0] pass_cnt; // Pass index in cycled mode
    logic [4:0] sample_idx; // Sample index of channels not averaged pass-wise
    logic [18:0] acc_mem [0:29]; // Running sums per channel
    logic [15:0] result_mem [0:29]; // Averaged results

    // Register write port
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cell_count_reg <= cmas_pkg::RST_CELL_COUNT;
            channel_sel <= cmas_pkg::RST_CHANNEL_SEL;
            ovs_code <= cmas_pkg::RST_OVS_CODE;
            cycled_average_select <= 1'b0;
            high_side_oversample_period <= cmas_pkg::RST_OVS_PERIOD;
            general_oversample_period <= cmas_pkg::RST_OVS_PERIOD;
            cell_sample_period_reg <= cmas_pkg::RST_SAMPLE_PERIOD;
            aux_sample_period_reg <= cmas_pkg::RST_SAMPLE_PERIOD;
            internal_sample_period_reg <= cmas_pkg::RST_SAMPLE_PERIOD;
            stack_voltage_monitor_enable <= 1'b0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                cmas_pkg::ADDR_CELL_COUNT: begin
                    cell_count_reg <= reg_wdata_i[4:0];
                end
                cmas_pkg::ADDR_CHANNEL_SEL: begin
                    channel_sel <= reg_wdata_i[29:0];
                end
                cmas_pkg::ADDR_OVERSAMPLE: begin
                    // Codes above 5 clamp to 32 samples
                    ovs_code <= (reg_wdata_i[2:0] > 3'h5) ? 3'h5
                        : reg_wdata_i[2:0];
                    cycled_average_select <=
                        reg_wdata_i[cmas_pkg::OVS_CYCLED_BIT];
                    high_side_oversample_period <=
                        reg_wdata_i[cmas_pkg::OVS_HPER_LSB +: 8];
                    general_oversample_period <=
                        reg_wdata_i[cmas_pkg::OVS_GPER_LSB +: 8];
                end
                cmas_pkg::ADDR_CELL_PERIOD: begin
                    cell_sample_period_reg <= reg_wdata_i[15:0];
                end
                cmas_pkg::ADDR_AUX_PERIOD: begin
                    aux_sample_period_reg <= reg_wdata_i[15:0];
                end
                cmas_pkg::ADDR_INTERNAL_PERIOD: begin
                    internal_sample_period_reg <= reg_wdata_i[15:0];
                end
                cmas_pkg::ADDR_TEST_CONFIG: begin
                    stack_voltage_monitor_enable <=
                        reg_wdata_i[cmas_pkg::TEST_STACK_EN_BIT];
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
    end

    // Command write decode
    always_comb begin
        cmd_start = reg_wr_i && reg_addr_i == cmas_pkg::ADDR_COMMAND
            && reg_wdata_i[cmas_pkg::CMD_START_BIT];
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic bcast_meta; // First stage, read only by bcast_sync
    logic bcast_sync; // Second stage
    logic bcast_prev; // Edge detector history
    logic [13:0] adc_meta; // First stage of converter data
    logic [13:0] adc_sync; // Stable converter data

    // Two flops for the broadcast start and converter data levels
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            bcast_meta <= 1'b0;
            bcast_sync <= 1'b0;
            bcast_prev <= 1'b0;
            adc_meta <= 14'h0000;
            adc_sync <= 14'h0000;
        end else begin
            bcast_meta <= broadcast_start_i;
            bcast_sync <= bcast_meta;
            bcast_prev <= bcast_sync;
            adc_meta <= adc_data_i;
            adc_sync <= adc_meta;
        end
    end

    // ------------------------------------------------------------
    // Run-order decode
    // ------------------------------------------------------------
    logic [29:0] pos_mask; // Enabled channels by position
    logic [4:0] cur_code; // Code at current position
    logic [4:0] rest_code; // Idle mux channel
    logic run_start; // Start request taken
    logic cyc_mode; // Pass-wise averaging active
    logic in_cyc; // Current channel is pass-wise
    logic [2:0] k_shift; // log2 samples of current channel
    logic is_first; // First sample of current channel
    logic is_last; // Last sample of current channel
    logic [18:0] new_sum; // Sum including this sample
    logic [5:0] nxt_a; // Next cell/aux in this pass
    logic [5:0] first_a; // First cell/aux of a pass
    logic [5:0] first_b; // First internal channel
    logic [5:0] nxt_all; // Next channel in run order
    logic [5:0] first_all; // First channel of a run
    logic [19:0] acq_cyc; // Acquisition length of next sample

    // Position mask, cells above the count dropped
    always_comb begin
        for (int p = 0; p < 30; p++) begin
            if (p < 16) begin
                pos_mask[p] = channel_sel[15 - p]
                    && 5'(15 - p) < cell_count_reg;
            end else begin
                pos_mask[p] = channel_sel[p];
            end
        end
    end

    // Per-sample decode of current position
    always_comb begin
        cur_code = pos_code(pos);
        rest_code = (cell_count_reg == 5'h00) ? 5'h00
            : cell_count_reg - 5'h01;
        run_start = cmd_start || (bcast_sync && !bcast_prev);
        cyc_mode = cycled_average_select && ovs_code != 3'h0;
        in_cyc = cyc_mode && pos < cmas_pkg::POS_INTERNAL;
        if (cur_code == cmas_pkg::CODE_DIG_TEMP) begin
            k_shift = 3'h0;
        end else if (cur_code == cmas_pkg::CODE_STACK) begin
            k_shift = stack_voltage_monitor_enable ? 3'h1
                : 3'h0;
        end else begin
            k_shift = ovs_code;
        end
        is_first = in_cyc ? pass_cnt == 5'h00 : sample_idx == 5'h00;
        is_last = in_cyc ? pass_cnt == 5'((6'h01 << k_shift) - 6'h01)
            : sample_idx == 5'((6'h01 << k_shift) - 6'h01);
        new_sum = is_first ? {5'h00, adc_sync}
            : acc_mem[cur_code] + {5'h00, adc_sync};
        nxt_a = find_pos(pos_mask, pos + 6'h01, cmas_pkg::POS_INTERNAL);
        first_a = find_pos(pos_mask, 6'h00, cmas_pkg::POS_INTERNAL);
        first_b = find_pos(pos_mask, cmas_pkg::POS_INTERNAL,
            cmas_pkg::POS_END);
        nxt_all = find_pos(pos_mask, pos + 6'h01, cmas_pkg::POS_END);
        first_all = find_pos(pos_mask, 6'h00, cmas_pkg::POS_END);
    end

    // Acquisition length: first sample by type, others by mode
    always_comb begin
        acq_cyc = 20'h00000;
        if (cur_code < cmas_pkg::CODE_AUX_FIRST) begin
            if (is_first || cycled_average_select) begin
                acq_cyc = 20'(cell_sample_period_reg
                    * cmas_pkg::PERIOD_UNIT_CYC);
            end else begin
                acq_cyc = 20'(high_side_oversample_period
                    * cmas_pkg::PERIOD_UNIT_CYC);
            end
        end else if (cur_code < cmas_pkg::CODE_DIG_TEMP) begin
            if (is_first || cycled_average_select) begin
                acq_cyc = 20'(aux_sample_period_reg
                    * cmas_pkg::PERIOD_UNIT_CYC);
            end else begin
                acq_cyc = 20'(general_oversample_period
                    * cmas_pkg::PERIOD_UNIT_CYC);
            end
        end else if (cur_code == cmas_pkg::CODE_DIG_TEMP) begin
            acq_cyc = 20'(DIG_TEMP_CYC);
        end else if (cur_code == cmas_pkg::CODE_CORE_SUPPLY) begin
            acq_cyc = is_first ? 20'(cmas_pkg::CORE_ACQ_CYC)
                : 20'(general_oversample_period
                * cmas_pkg::PERIOD_UNIT_CYC);
        end else begin
            acq_cyc = is_first ? 20'(internal_sample_period_reg
                * cmas_pkg::PERIOD_UNIT_CYC)
                : 20'(high_side_oversample_period
                * cmas_pkg::PERIOD_UNIT_CYC);
        end
        // A zero period still needs one cycle to settle
        if (acq_cyc == 20'h00000) begin
            acq_cyc = 20'h00001;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // State, counters and mux; new starts ignored while busy
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state <= cmas_pkg::CMAS_IDLE;
            wait_cnt <= 20'h00000;
            pos <= 6'h00;
            pass_cnt <= 5'h00;
            sample_idx <= 5'h00;
            busy_o <= 1'b0;
            adc_hold_o <= 1'b0;
            adc_mux_sel_o <= 5'h00;
        end else begin
            unique case (state)
                cmas_pkg::CMAS_IDLE: begin
                    adc_mux_sel_o <= rest_code;
                    if (run_start && !first_all[5]) begin
                        pos <= first_all;
                        pass_cnt <= 5'h00;
                        sample_idx <= 5'h00;
                        busy_o <= 1'b1;
                        adc_mux_sel_o <= pos_code(first_all);
                        state <= cmas_pkg::CMAS_SETUP;
                    end
                end
                cmas_pkg::CMAS_SETUP: begin
                    wait_cnt <= acq_cyc - 20'h00001;
                    state <= cmas_pkg::CMAS_ACQ;
                end
                cmas_pkg::CMAS_ACQ: begin
                    if (wait_cnt == 20'h00000) begin
                        wait_cnt <= 20'(cmas_pkg::HOLD_CYC - 1);
                        adc_hold_o <= 1'b1;
                        state <= cmas_pkg::CMAS_CONV;
                    end else begin
                        wait_cnt <= wait_cnt - 20'h00001;
                    end
                end
                cmas_pkg::CMAS_CONV: begin
                    if (wait_cnt != 20'h00000) begin
                        wait_cnt <= wait_cnt - 20'h00001;
                    end else begin
                        adc_hold_o <= 1'b0;
                        state <= cmas_pkg::CMAS_SETUP;
                        if (in_cyc) begin
                            if (!nxt_a[5]) begin
                                pos <= nxt_a;
                                adc_mux_sel_o <= pos_code(nxt_a);
                            end else if (!is_last) begin
                                pass_cnt <= pass_cnt + 5'h01;
                                pos <= first_a;
                                adc_mux_sel_o <= pos_code(first_a);
                            end else if (!first_b[5]) begin
                                pos <= first_b;
                                sample_idx <= 5'h00;
                                adc_mux_sel_o <= pos_code(first_b);
                            end else begin
                                busy_o <= 1'b0;
                                adc_mux_sel_o <= rest_code;
                                state <= cmas_pkg::CMAS_IDLE;
                            end
                        end else if (!is_last) begin
                            sample_idx <= sample_idx + 5'h01;
                        end else if (!nxt_all[5]) begin
                            sample_idx <= 5'h00;
                            pos <= nxt_all;
                            adc_mux_sel_o <= pos_code(nxt_all);
                        end else begin
                            busy_o <= 1'b0;
                            adc_mux_sel_o <= rest_code;
                            state <= cmas_pkg::CMAS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Accumulate samples; only the average becomes visible
    always_ff @(posedge clk_sys_i) begin
        if (state == cmas_pkg::CMAS_CONV && wait_cnt == 20'h00000) begin
            acc_mem[cur_code] <= new_sum;
            if (is_last) begin
                result_mem[cur_code] <= scale_avg(new_sum,
                    k_shift);
            end
        end
    end

    // ------------------------------------------------------------
    // Fault masking and read port
    // ------------------------------------------------------------
    // Cells above the count: faults masked, comparators off
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cell_fault_mask_o <= 16'h0000;
            cell_cmp_enable_o <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                cell_fault_mask_o[i] <= 5'(i) >= cell_count_reg;
                cell_cmp_enable_o[i] <= 5'(i) < cell_count_reg;
            end
        end
    end

    // Read data one cycle after strobe; zero otherwise
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_addr_i >= cmas_pkg::ADDR_RESULT_BASE
                && reg_addr_i <= cmas_pkg::ADDR_RESULT_LAST) begin
            reg_rdata_o <= {16'h0000, result_mem[5'(reg_addr_i
                - cmas_pkg::ADDR_RESULT_BASE)]};
        end else begin
            unique case (reg_addr_i)
                cmas_pkg::ADDR_COMMAND: begin
                    // Status: busy, state, current channel
                    reg_rdata_o <= {23'h000000, busy_o, state, 1'b0,
                        cur_code};
                end
                cmas_pkg::ADDR_CELL_COUNT: begin
                    reg_rdata_o <= {27'h0000000, cell_count_reg};
                end
                cmas_pkg::ADDR_CHANNEL_SEL: begin
                    reg_rdata_o <= {2'h0, channel_sel};
                end
                cmas_pkg::ADDR_OVERSAMPLE: begin
                    reg_rdata_o <= {8'h00, general_oversample_period,
                        high_side_oversample_period, 4'h0,
                        cycled_average_select, ovs_code};
                end
                cmas_pkg::ADDR_CELL_PERIOD: begin
                    reg_rdata_o <= {16'h0000, cell_sample_period_reg};
                end
                cmas_pkg::ADDR_AUX_PERIOD: begin
                    reg_rdata_o <= {16'h0000, aux_sample_period_reg};
                end
                cmas_pkg::ADDR_INTERNAL_PERIOD: begin
                    reg_rdata_o <= {16'h0000,
                        internal_sample_period_reg};
                end
                cmas_pkg::ADDR_TEST_CONFIG: begin
                    reg_rdata_o <= {31'h00000000,
                        stack_voltage_monitor_enable};
                end
                default: begin
                    reg_rdata_o <= 32'h00000000;
                end
            endcase
        end
    end
endmodule // cmas_sequencer

// ---- bench/cmas_monitor.sv ----
`timescale 1ns/100ps
// ------------------------------
// Sequencer port checks
// ------------------------------
module cmas_monitor (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic broadcast_start_i,
    input wire logic [13:0] adc_data_i,
    input wire logic [4:0] adc_mux_sel_o,
    input wire logic adc_hold_o,
    input wire logic busy_o,
    input wire logic [15:0] cell_fault_mask_o,
    input wire logic [15:0] cell_cmp_enable_o
);
    // Edges since release; outputs are settled by the third
    logic [2:0] up;
    // Cycles spent in the current hold phase
    int hc;
    always_ff @(posedge clk_sys_i) begin
        up <= nrst_i ? {up[1:0], 1'b1} : 3'h0;
    end
    always_ff @(posedge clk_sys_i) begin
        hc <= adc_hold_o ? hc + 1 : 0;
    end
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    a_hold_len: assert property (
        $fell(adc_hold_o) |-> hc == cmas_pkg::HOLD_CYC) else $error("Bad hold");
    a_hold_busy: assert property (
        adc_hold_o |-> busy_o) else $error("Hold while idle");
    a_hold_mux: assert property (
        adc_hold_o |-> $stable(adc_mux_sel_o)) else $error("Mux moved in hold");
    a_run_end: assert property (
        $fell(busy_o) |-> $fell(adc_hold_o)) else $error("Run ended early");
    a_start_busy: assert property (
        up[2] && reg_wr_i && reg_addr_i == cmas_pkg::ADDR_COMMAND
        && reg_wdata_i[0] && !busy_o |=> busy_o) else $error("No start");
    a_mask_pair: assert property (
        up[2] |-> cell_fault_mask_o == ~cell_cmp_enable_o) else $error("Mask");
    a_mask_fill: assert property (
        up[2] |-> ((17'(cell_cmp_enable_o) + 17'h1) & 17'(cell_cmp_enable_o))
        == 17'h0) else $error("Enabled cells not contiguous");
    a_idle_rest: assert property (
        up[2] && !busy_o && $stable(cell_cmp_enable_o) |-> adc_mux_sel_o ==
        5'($countones(cell_cmp_enable_o) - (cell_cmp_enable_o != 16'h0)))
        else $error("Idle mux off rest channel");
endmodule // cmas_monitor
bind cmas_sequencer cmas_monitor mon (.*);

// ---- bench/cmas_cell_stack.sv ----
`timescale 1ns/100ps
// ------------------------------
// Cell stack seen by the converter
// ------------------------------
module cmas_cell_stack (
    input wire logic clk_sys_i,
    input wire logic [4:0] adc_mux_sel_i,
    input wire logic adc_hold_i,
    output logic [13:0] adc_data_o
);
    // Dither flips after each hold, so a lost sample shows
    logic t = 1'b0;
    logic hq = 1'b0;
    always_ff @(posedge clk_sys_i) begin
        hq <= adc_hold_i;
        t <= t ^ (hq & !adc_hold_i);
    end
    // Level scales with the channel code
    assign adc_data_o = {5'h0, adc_mux_sel_i, 3'h0, t};
endmodule // cmas_cell_stack

// ---- bench/tb_cmas_sequencer.sv ----
`timescale 1ns/100ps
// ------------------------------
// Sequencer testbench
// ------------------------------
module tb_cmas_sequencer;
    logic clk_sys_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic broadcast_start_i = 0, adc_hold_o, busy_o, hold_q = 0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [13:0] adc_data_i;
    logic [4:0] adc_mux_sel_o;
    logic [15:0] cell_fault_mask_o, cell_cmp_enable_o;
    logic [4:0] seen[$];
    int mismatches = 0, tests_run = 0, cycles = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    cmas_sequencer uut (.*);
    cmas_cell_stack cells (.clk_sys_i, .adc_mux_sel_i(adc_mux_sel_o),
        .adc_hold_i(adc_hold_o), .adc_data_o(adc_data_i));
    // Log channel at each hold start; cut a hang short
    always @(posedge clk_sys_i) begin
        cycles++;
        hold_q <= adc_hold_o;
        if (adc_hold_o && !hold_q) seen.push_back(adc_mux_sel_o);
        if (cycles == 95000) begin
            mismatches++;
            give_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(reg_rdata_o, e);
    endtask
    // Odd codes run per channel, even codes cycle cell 2, cell 1, aux 0
    function automatic logic [4:0] exp_code(int k, int n);
        int i;
        i = n[0] ? k >> n : k % 3;
        return i == 0 ? 5'h01 : (i == 1 ? 5'h00 : 5'h10);
    endfunction
    task run(input int n);
        seen.delete();
        wr(8'h03, {28'h0, !n[0], n[2:0]});
        if (n == 5) begin
            @(posedge clk_sys_i);
            broadcast_start_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            broadcast_start_i <= 1'b0;
        end else begin
            wr(8'h00, 32'h1);
        end
        wr(8'h00, 32'h1);
        while (busy_o !== 1'b0) @(negedge clk_sys_i);
        chk(seen.size(), 3 << n);
        foreach (seen[k]) chk(seen[k], exp_code(k, n));
        rd(8'h21, 32'h0042);
        rd(8'h30, 32'h0402);
        chk(adc_mux_sel_o, 5'h01);
        $display("Run with code %0d done", n);
    endtask
    task give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset values, two cells plus one aux, then oversample codes 1 to 5
    initial begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(8'h01, 32'h00000010);
        rd(8'h03, 32'h009E9E00);
        rd(8'h04, 32'h0000009E);
        rd(8'h3F, 32'h0);
        wr(8'h01, 32'h2);
        wr(8'h02, 32'h0001FFFF);
        for (int a = 4; a < 7; a++) wr(a[7:0], 32'h0);
        @(negedge clk_sys_i);
        chk(cell_fault_mask_o, 32'h0000FFFC);
        chk(cell_cmp_enable_o, 32'h00000003);
        $display("Register checks done");
        for (int n = 1; n < 6; n++) run(n);
        give_verdict();
    end
endmodule // tb_cmas_sequencer
